// ===== hdl/cbsq_pkg.sv
// package of constants and carriers for the bus state clock qualifier
package cbsq_pkg;
  // apb register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;
  localparam logic [7:0] CNT_OFF = 8'h08;
  // control register fields
  localparam int CTRL_CUSTOM_BIT = 0;
  localparam int CTRL_DELAY_LSB = 1;
  localparam int CTRL_SYNC_LVL_BIT = 3;
  localparam int CTRL_WAIT_LVL_BIT = 4;
  localparam int CTRL_FALL_BIT = 5;
  // default qualification: rising edge, delay 2, sync at 0, wait at 1
  localparam logic [1:0] DEFAULT_DELAY = 2'h2;
  localparam logic DEFAULT_SYNC_LVL = 1'b0;
  localparam logic DEFAULT_WAIT_LVL = 1'b1;
  localparam logic [31:0] CTRL_RESET = 32'h00000004;

  // processor side inputs, sampled as synchronous to pclk
  typedef struct packed {
    logic proc_clk;     // processor clock
    logic [4:0] irq_in; // interrupt inputs, high when requesting
    logic io_m;         // processor io/memory select
    logic rd_n;         // read strobe, low active
    logic wr_n;         // write strobe, low active
    logic inta_n;       // interrupt acknowledge, low active
    logic ale;          // address latch strobe
    logic ready;        // ready input
    logic halt_n;       // halt input, low active
    logic hold;         // hold input
  } cbsq_proc_t;

  // analyzer control channels
  typedef struct packed {
    logic read_write;             // 0 write, 1 read
    logic io_mem_select;          // 1 io, 0 memory
    logic interrupt_request_flag;
    logic interrupt_ack_flag;
    logic hold_flag;
    logic indication_a_channel;
    logic sync_channel;
    logic wait_channel;
  } cbsq_chan_t;

  // state clock configuration
  typedef struct packed {
    logic custom;
    logic [1:0] delay;
    logic sync_lvl;
    logic wait_lvl;
    logic falling;
  } cbsq_cfg_t;
endpackage

// ===== hdl/cbsq_strobe.sv
// state clock generator: sync, wait hold-off and delay on the edge pulse selected in the top
`timescale 1ns/1ns
module cbsq_strobe (
  input wire logic pclk,               // system clock
  input wire logic presetn,            // async reset, low active
  input wire logic edge_en,            // one-cycle pulse at selected processor clock edge
  input wire logic sync_hit,           // sync channel at its qualifying level
  input wire logic wait_hit,           // wait channel at its qualifying level
  input wire logic [1:0] delay,        // clock delay setting
  output logic strobe                  // one-cycle storage strobe
);
  typedef struct packed {
    logic [1:0] cnt;
    logic armed;
    logic strobe;
  } cbsq_strobe_st_t;
  cbsq_strobe_st_t st_reg, st_next;

  // count edges from the sync edge; a wait state freezes the count
  always_comb begin
    st_next = st_reg;
    st_next.strobe = 1'b0;
    if (edge_en) begin
      if (delay == 2'h0) begin
        st_next.strobe = 1'b1; // RULE_08
        // drop any half-done count so a later delay setting starts clean
        st_next.armed = 1'b0;
      end else if (sync_hit) begin
        st_next.cnt = 2'h0; // RULE_06
        st_next.armed = 1'b1;
      end else if (st_reg.armed && !wait_hit) begin // RULE_13
        if (st_reg.cnt + 2'h1 == delay) begin
          st_next.strobe = 1'b1; // RULE_07
          st_next.armed = 1'b0;
        end
        st_next.cnt = st_reg.cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign strobe = st_reg.strobe;

  a_one_per_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    (delay != 2'h0 && st_reg.strobe) |-> !st_reg.armed) // RULE_07
    else $error("strobe left the counter armed");
  a_wait_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (edge_en && wait_hit && !sync_hit && delay != 2'h0) |=> $stable(st_reg.cnt)) // RULE_13
    else $error("count moved during wait");
endmodule

// ===== hdl/cbsq_top.sv
// top of the bus state clock qualifier with apb control
// Contract
// RULE_01 - request flag high when any interrupt requested
// RULE_02 - io select one for io, zero memory
// RULE_03 - processor holds io select high during acknowledge
// RULE_04 - address latch strobe routed to sync channel
// RULE_05 - wait channel high while ready low
// RULE_06 - default: rising edge, sync0, wait1, delay two
// RULE_07 - one storage strobe per machine cycle
// RULE_08 - delay zero gives strobe every T state
// RULE_09 - setting changes apply; default restores configuration
// RULE_10 - only request flag and io select stored
// RULE_11 - indication_a when halt low, ready low, hold high
// RULE_12 - read-write channel zero write, one read
// RULE_13 - wait freezes delay count until wait ends
`timescale 1ns/1ns
module cbsq_top (
  input wire logic pclk,                    // 100 MHz clock
  input wire logic presetn,                 // async reset, low active
  input wire logic psel,                    // apb select
  input wire logic penable,                 // apb enable
  input wire logic pwrite,                  // apb direction
  input wire logic [7:0] paddr,             // apb byte address
  input wire logic [31:0] pwdata,           // apb write data
  output logic [31:0] prdata,               // apb read data
  output logic pready,                      // apb ready
  output logic pslverr,                     // apb error on unmapped address
  input wire cbsq_pkg::cbsq_proc_t proc_in, // processor pins
  output cbsq_pkg::cbsq_chan_t chan,        // all control channels
  output logic [1:0] stored_chan,           // stored: {request flag, io select}
  output logic state_clk                    // storage strobe
);
  typedef struct packed {
    logic [31:0] ctrl;
    logic [15:0] cnt;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    cbsq_pkg::cbsq_chan_t chan;
    logic [1:0] stored;
    logic proc_clk_d;
    logic state_clk;
  } cbsq_st_t;
  cbsq_st_t st_reg, st_next;
  cbsq_pkg::cbsq_cfg_t cfg;
  logic edge_en;
  logic sync_hit;
  logic wait_hit;
  logic strobe;
  logic acc;
  logic mapped;

  // custom bit clear falls back to the default qualification
  always_comb begin
    if (st_reg.ctrl[cbsq_pkg::CTRL_CUSTOM_BIT]) begin
      cfg.custom = 1'b1; // RULE_09
      cfg.delay = st_reg.ctrl[cbsq_pkg::CTRL_DELAY_LSB +: 2];
      cfg.sync_lvl = st_reg.ctrl[cbsq_pkg::CTRL_SYNC_LVL_BIT];
      cfg.wait_lvl = st_reg.ctrl[cbsq_pkg::CTRL_WAIT_LVL_BIT];
      cfg.falling = st_reg.ctrl[cbsq_pkg::CTRL_FALL_BIT];
    end else begin
      cfg.custom = 1'b0; // RULE_06
      cfg.delay = cbsq_pkg::DEFAULT_DELAY;
      cfg.sync_lvl = cbsq_pkg::DEFAULT_SYNC_LVL;
      cfg.wait_lvl = cbsq_pkg::DEFAULT_WAIT_LVL;
      cfg.falling = 1'b0;
    end
  end

  // processor clock edge detect; inputs are already synchronous
  assign edge_en = cfg.falling ? (st_reg.proc_clk_d && !proc_in.proc_clk)
                               : (!st_reg.proc_clk_d && proc_in.proc_clk);
  // qualify on the pins as they stand at the detected edge; the registered
  // channels lag one pclk, which would push the sync edge past T1
  assign sync_hit = ((!proc_in.ale) == cfg.sync_lvl); // RULE_06
  assign wait_hit = ((!proc_in.ready) == cfg.wait_lvl); // RULE_13

  cbsq_strobe u_strobe (
    .pclk(pclk),
    .presetn(presetn),
    .edge_en(edge_en),
    .sync_hit(sync_hit),
    .wait_hit(wait_hit),
    .delay(cfg.delay),
    .strobe(strobe)
  );

  assign acc = psel && penable;
  assign mapped = (paddr == cbsq_pkg::CTRL_OFF) || (paddr == cbsq_pkg::STAT_OFF) ||
                  (paddr == cbsq_pkg::CNT_OFF);

  // channel derivation, apb slave and strobe counter
  always_comb begin
    st_next = st_reg;
    st_next.proc_clk_d = proc_in.proc_clk;
    st_next.chan.interrupt_request_flag = |proc_in.irq_in; // RULE_01
    st_next.chan.io_mem_select = proc_in.io_m; // RULE_02
    st_next.chan.interrupt_ack_flag = !proc_in.inta_n; // RULE_03
    st_next.chan.hold_flag = proc_in.hold;
    st_next.chan.sync_channel = !proc_in.ale; // RULE_04
    st_next.chan.wait_channel = !proc_in.ready; // RULE_05
    st_next.chan.indication_a_channel = !proc_in.halt_n || !proc_in.ready || proc_in.hold; // RULE_11
    st_next.chan.read_write = !proc_in.rd_n; // RULE_12
    st_next.state_clk = strobe;
    if (strobe) begin
      // only request flag and io select are stored
      st_next.stored = {st_reg.chan.interrupt_request_flag, st_reg.chan.io_mem_select}; // RULE_10
      st_next.cnt = st_reg.cnt + 16'h0001;
    end
    st_next.pready = 1'b0;
    st_next.pslverr = 1'b0;
    // single wait state: answer one cycle into the access phase
    if (psel && !penable) begin
      st_next.pready = 1'b0;
    end
    if (acc && !st_reg.pready) begin
      st_next.pready = 1'b1;
      st_next.pslverr = !mapped;
      st_next.prdata = 32'h00000000;
      if (!pwrite) begin
        unique case (paddr)
          cbsq_pkg::CTRL_OFF: st_next.prdata = st_reg.ctrl;
          cbsq_pkg::STAT_OFF: st_next.prdata = {24'h000000, st_reg.chan};
          cbsq_pkg::CNT_OFF: st_next.prdata = {16'h0000, st_reg.cnt};
          default: st_next.prdata = 32'h00000000;
        endcase
      end
    end
    // the write lands on the edge that completes the transfer, pready seen high
    if (acc && st_reg.pready && pwrite && paddr == cbsq_pkg::CTRL_OFF) begin
      st_next.ctrl = {26'h0, pwdata[5:0]}; // RULE_09
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.ctrl <= cbsq_pkg::CTRL_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign chan = st_reg.chan;
  assign stored_chan = st_reg.stored;
  assign state_clk = st_reg.state_clk;

  a_irq_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (|proc_in.irq_in) |=> chan.interrupt_request_flag) // RULE_01
    else $error("request flag not raised");
  a_io_select: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 chan.io_mem_select == $past(proc_in.io_m)) // RULE_02
    else $error("io select mismatch");
  a_sync_route: assert property (@(posedge pclk) disable iff (!presetn)
    proc_in.ale |=> !chan.sync_channel) // RULE_04
    else $error("sync channel not low during latch strobe");
  a_wait_chan: assert property (@(posedge pclk) disable iff (!presetn)
    !proc_in.ready |=> chan.wait_channel && chan.indication_a_channel) // RULE_05
    else $error("wait channel not raised");
  a_indication_a_chan: assert property (@(posedge pclk) disable iff (!presetn)
    (!proc_in.halt_n || proc_in.hold) |=> chan.indication_a_channel) // RULE_11
    else $error("indication_a channel not raised");
  a_rw_code: assert property (@(posedge pclk) disable iff (!presetn)
    (!proc_in.rd_n && proc_in.wr_n) |=> chan.read_write) // RULE_12
    else $error("read not encoded as one");
  a_default_cfg: assert property (@(posedge pclk) disable iff (!presetn)
    !st_reg.ctrl[0] |-> cfg.delay == 2'h2 && !cfg.sync_lvl && cfg.wait_lvl) // RULE_06
    else $error("default qualification not in force");
  a_zero_delay: assert property (@(posedge pclk) disable iff (!presetn)
    (edge_en && cfg.delay == 2'h0) |=> ##1 state_clk) // RULE_08
    else $error("no strobe per T state");
  a_store_pair: assert property (@(posedge pclk) disable iff (!presetn)
    strobe |=> stored_chan == $past({chan.interrupt_request_flag, chan.io_mem_select})) // RULE_10
    else $error("stored channels wrong");
endmodule

// ===== test/cbsq_proc_model.sv
// behavioural target processor: T states, address strobe, waits and status pins
`timescale 1ns/1ns
module cbsq_proc_model (
  input wire logic pclk,                // system clock
  input wire logic presetn,             // async reset, low active
  input wire logic [1:0] nwait,         // wait states per machine cycle
  input wire logic [4:0] irq,           // interrupt requests
  input wire logic ack,                 // acknowledge cycle in progress
  input wire logic io,                  // io access
  input wire logic wrt,                 // write cycle
  input wire logic halt_n,              // halt pin, low active
  input wire logic hold,                // hold pin
  output cbsq_pkg::cbsq_proc_t proc_in  // pins seen by the block
);
  logic [2:0] ph;
  logic [2:0] ts;
  // eight pclk per T state, state index wraps after T3
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph <= 3'h0;
      ts <= 3'h0;
    end else begin
      ph <= ph + 3'h1;
      if (ph == 3'h7) begin
        ts <= (ts == 3'h2 + nwait) ? 3'h0 : ts + 3'h1;
      end
    end
  end
  // ready falls mid T2 and rises mid last wait, so rising edges in waits see it low
  always_comb begin
    proc_in.proc_clk = ~ph[2];
    proc_in.irq_in = irq;
    proc_in.io_m = io | ack;
    proc_in.rd_n = wrt | (ts == 3'h0);
    proc_in.wr_n = !wrt | (ts == 3'h0);
    proc_in.inta_n = !ack;
    proc_in.ale = (ts == 3'h0);
    proc_in.ready = !(nwait != 2'h0 && ((ts == 3'h1 && ph[2]) ||
      (ts >= 3'h2 && ts < 3'h1 + nwait) || (ts >= 3'h2 && ts == 3'h1 + nwait && !ph[2])));
    proc_in.halt_n = halt_n;
    proc_in.hold = hold;
  end
endmodule

// ===== test/tb_top.sv
// self-checking bench for the bus state clock qualifier
`timescale 1ns/1ns
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] nwait = 2'h1;
  logic [9:0] pins = 10'h002;
  cbsq_pkg::cbsq_proc_t proc_in;
  cbsq_pkg::cbsq_proc_t prv;
  cbsq_pkg::cbsq_chan_t chan;
  logic [1:0] stored_chan;
  logic state_clk;
  logic [31:0] q;
  logic e;
  int pulses = 0;
  int t1_hits = 0;
  int mismatches = 0;
  int cmp_count = 0;
  always #5 pclk = ~pclk;
  // previous pin sample, what the block registered at the last edge
  always @(posedge pclk) prv <= proc_in;
  // strobes counted, and those that fall in T1 (address strobe high) as well
  always @(negedge pclk) begin
    if (state_clk === 1'b1) pulses++;
    if (state_clk === 1'b1 && proc_in.ale === 1'b1) t1_hits++;
  end
  cbsq_proc_model i_proc (.pclk(pclk), .presetn(presetn), .nwait(nwait), .irq(pins[9:5]),
    .ack(pins[4]), .io(pins[3]), .wrt(pins[2]), .halt_n(pins[1]), .hold(pins[0]),
    .proc_in(proc_in));
  cbsq_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .proc_in(proc_in), .chan(chan), .stored_chan(stored_chan),
    .state_clk(state_clk));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // request held until the rising edge that sees pready; answer taken at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) mismatches++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_regs;
    apb(1'b0, cbsq_pkg::CTRL_OFF, 32'h0);
    chk(q, cbsq_pkg::CTRL_RESET);
    apb(1'b0, 8'h0c, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
  endtask
  // rows: {irq, ack, io, write, halt_n, hold}
  task automatic t_chan;
    logic [9:0] tab [4];
    tab = '{10'h002, 10'h216, 10'h02c, 10'h003};
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk);
      pins <= tab[i];
      repeat (80) begin
        @(negedge pclk);
        chk(chan, {!prv.rd_n, prv.io_m, |prv.irq_in, !prv.inta_n, prv.hold,
          !prv.halt_n | !prv.ready | prv.hold, !prv.ale, !prv.ready});
      end
      chk(stored_chan, {|tab[i][9:5], tab[i][4] | tab[i][3]});
    end
    @(posedge pclk);
    pins <= 10'h002;
  endtask
  // strobes in four whole machine cycles, after two to settle; only a strobe
  // per T state may land in T1, and the strobe counter must agree
  task automatic t_strobe(input logic [31:0] c, input logic [1:0] nw, input int mult);
    int base;
    int base1;
    apb(1'b1, cbsq_pkg::CTRL_OFF, c);
    apb(1'b0, cbsq_pkg::CTRL_OFF, 32'h0);
    chk(q, c & 32'h3f);
    nwait <= nw;
    repeat (16 * (3 + nw)) @(posedge pclk);
    base = pulses;
    base1 = t1_hits;
    repeat (32 * (3 + nw)) @(posedge pclk);
    chk(pulses - base, 4 * mult);
    chk(t1_hits - base1, (mult == 1) ? 0 : 4);
    // count read at the completing edge lags a strobe registered at the edge before
    apb(1'b0, cbsq_pkg::CNT_OFF, 32'h0);
    chk(q, pulses - state_clk);
  endtask
  task automatic report_and_stop;
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_chan();
    t_strobe(32'h0, 2'h0, 1);
    t_strobe(32'h0, 2'h2, 1);
    t_strobe(32'h11, 2'h0, 3);
    t_strobe(32'h35, 2'h0, 1);
    t_strobe(32'h10, 2'h1, 1);
    report_and_stop();
  end
  // the whole sequence needs well under ten thousand cycles
  initial begin
    #200000;
    mismatches++;
    report_and_stop();
  end
endmodule
